/* bench/stc_clk_src.sv */
`timescale 1ns/1ps

module stc_clk_src (
  input  wire logic core_clk,
  output logic      ext_count_clock_pin,
  output logic      osc_input_pin
);
  initial begin
    ext_count_clock_pin = 1'b0;
    osc_input_pin       = 1'b0;
  end
  // Six cycles high and low keeps clear of the input filter's minimum width
  task pulse(input bit use_osc, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      if (use_osc) osc_input_pin <= 1'b1;
      else ext_count_clock_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      osc_input_pin       <= 1'b0;
      ext_count_clock_pin <= 1'b0;
      repeat (5) @(posedge core_clk);
    end
  endtask : pulse
endmodule : stc_clk_src

/* bench/stc_timer_asserts.sv */
`timescale 1ns/1ps
`include "stc_consts.svh"

module stc_timer_asserts (
  input wire logic                  core_clk,
  input wire logic                  nrst,
  input wire stc_pkg::stc_bus_req_t bus_req,
  input wire logic           [7:0]  rdata,
  input wire logic                  sleep,
  input wire logic           [1:0]  special_event_trig,
  input wire logic                  ext_count_clock_pin,
  input wire logic                  osc_input_pin,
  input wire logic                  irq,
  input wire logic                  osc_run,
  input wire logic                  osc_pins_input_only,
  input wire logic                  timebase_valid,
  input wire logic           [15:0] count_value
);
  import stc_pkg::*;
  logic cnt_wr;
  logic ctl_wr;
  logic trig_any;
  assign cnt_wr   = bus_req.wr && (bus_req.addr[7:1] == 7'h07);
  assign ctl_wr   = bus_req.wr && (bus_req.addr == `STC_ADDR_CONTROL);
  assign trig_any = |special_event_trig;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("rdata not zero outside read answer");
  a_ctrl_upper: assert property (bus_req.rd &&
    bus_req.addr == `STC_ADDR_CONTROL |=> rdata[7:6] == 2'h0)
    else $error("control upper bits not zero");
  a_osc_follow: assert property (ctl_wr |=>
    osc_run == $past(bus_req.wdata[3])) else $error("osc_run wrong");
  a_pins_input: assert property (osc_pins_input_only == osc_run)
    else $error("pin forcing differs from oscillator enable");
  a_timebase_mode: assert property (ctl_wr |=> timebase_valid ==
    !($past(bus_req.wdata[1]) && $past(bus_req.wdata[2])))
    else $error("timebase_valid wrong");
  a_write_wins: assert property (cnt_wr && !bus_req.addr[0] |=>
    count_value[7:0] == $past(bus_req.wdata))
    else $error("low byte write lost");
  a_trig_clear: assert property (trig_any && !cnt_wr |=>
    count_value == 16'h0000) else $error("trigger did not clear count");
  a_count_step: assert property (!$stable(count_value) &&
    !$past(cnt_wr) && !$past(trig_any) |->
    count_value == $past(count_value) + 16'h0001)
    else $error("count moved by other than one");
  c_irq: cover property ($rose(irq));
  c_trig: cover property (trig_any);
  c_free: cover property (!timebase_valid);
endmodule : stc_timer_asserts

bind stc_timer stc_timer_asserts u_asserts (.core_clk(core_clk), .nrst(nrst),
  .bus_req(bus_req), .rdata(rdata), .sleep(sleep),
  .special_event_trig(special_event_trig),
  .ext_count_clock_pin(ext_count_clock_pin), .osc_input_pin(osc_input_pin),
  .irq(irq), .osc_run(osc_run), .osc_pins_input_only(osc_pins_input_only),
  .timebase_valid(timebase_valid), .count_value(count_value));

/* bench/tb_top.sv */
`timescale 1ns/1ps
`include "stc_consts.svh"

module tb_top;
  import stc_pkg::*;
  logic          core_clk;
  logic          nrst;
  stc_bus_req_t  bus_req;
  logic [7:0]    rdata;
  logic          sleep;
  logic [1:0]    special_event_trig;
  logic          ext_pin;
  logic          osc_pin;
  logic          irq;
  logic          osc_run;
  logic          pins_in;
  logic          timebase_valid;
  logic [15:0]   count_value;
  logic [7:0]    d;
  int            fails;
  int            check_count;

  stc_timer dut (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
    .rdata(rdata), .sleep(sleep), .special_event_trig(special_event_trig),
    .ext_count_clock_pin(ext_pin), .osc_input_pin(osc_pin), .irq(irq),
    .osc_run(osc_run), .osc_pins_input_only(pins_in),
    .timebase_valid(timebase_valid), .count_value(count_value));
  stc_clk_src src (.core_clk(core_clk), .ext_count_clock_pin(ext_pin),
    .osc_input_pin(osc_pin));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task set_count(input logic [15:0] v);
    wr(`STC_ADDR_COUNT_LOW, v[7:0]);
    wr(`STC_ADDR_COUNT_HIGH, v[15:8]);
  endtask : set_count

  task t_regs;
    rd(`STC_ADDR_CONTROL); chk("ctrl reset", 16'h0000, d);
    chk("timebase reset", 16'h0001, timebase_valid);
    wr(`STC_ADDR_CONTROL, 8'hF8);
    rd(`STC_ADDR_CONTROL); chk("ctrl upper", 16'h0038, d);
    chk("osc_run", 16'h0001, osc_run);
    chk("pins input", 16'h0001, pins_in);
    wr(8'h20, 8'hA5); rd(8'h20); chk("unmapped", 16'h0000, d);
    wr(`STC_ADDR_CONTROL, 8'h00);
    set_count(16'hC35A);
    rd(`STC_ADDR_COUNT_HIGH); chk("count high", 16'h00C3, d);
    rd(`STC_ADDR_COUNT_LOW); chk("count low", 16'h005A, d);
  endtask : t_regs

  task t_irq;
    wr(`STC_ADDR_ENABLE, 8'h00);
    set_count(16'hFFFE);
    wr(`STC_ADDR_CONTROL, 8'h01);
    repeat (20) @(posedge core_clk);
    wr(`STC_ADDR_CONTROL, 8'h00);
    #1 chk("wrapped", 16'h0001, count_value < 16'h0004);
    chk("masked irq", 16'h0000, irq);
    wr(`STC_ADDR_ENABLE, 8'h01);
    #1 chk("unmasked irq", 16'h0001, irq);
    rd(`STC_ADDR_FLAG); chk("flag", 16'h0001, d[0]);
    rd(`STC_ADDR_FLAG); chk("flag clear", 16'h0000, d[0]);
    chk("irq clear", 16'h0000, irq);
    repeat (40) @(posedge core_clk);
    #1 chk("stopped", 16'h0001, count_value < 16'h0004);
  endtask : t_irq

  task t_prescale;
    for (int c = 0; c < 4; c++) begin
      set_count(16'h0000);
      wr(`STC_ADDR_CONTROL, 8'(c * 16 + 1));
      repeat (16 << c) @(posedge core_clk);
      #1 chk("ratio", 16'h0001, count_value >= 3 && count_value <= 5);
      wr(`STC_ADDR_CONTROL, 8'h00);
    end
  endtask : t_prescale

  task t_ext;
    set_count(16'h0000);
    wr(`STC_ADDR_CONTROL, 8'h03);
    src.pulse(1'b0, 5);
    src.pulse(1'b1, 3);
    repeat (10) @(posedge core_clk);
    chk("pin count", 16'h0005, count_value);
    wr(`STC_ADDR_CONTROL, 8'h0B);
    src.pulse(1'b0, 3);
    src.pulse(1'b1, 4);
    repeat (10) @(posedge core_clk);
    chk("osc count", 16'h0009, count_value);
    wr(`STC_ADDR_CONTROL, 8'h13);
    src.pulse(1'b0, 6);
    repeat (10) @(posedge core_clk);
    chk("ext ratio", 16'h000C, count_value);
    // Leave the 1:2 prescaler half way, then a count write must empty it
    src.pulse(1'b0, 1);
    wr(`STC_ADDR_COUNT_LOW, 8'h40);
    src.pulse(1'b0, 1);
    repeat (10) @(posedge core_clk);
    #1 chk("presc clear", 16'h0040, count_value);
  endtask : t_ext

  task t_sleep;
    set_count(16'hFFFF);
    wr(`STC_ADDR_CONTROL, 8'h03);
    sleep <= 1'b1;
    src.pulse(1'b0, 3);
    repeat (10) @(posedge core_clk);
    chk("sync sleep", 16'hFFFF, count_value);
    wr(`STC_ADDR_CONTROL, 8'h07);
    #1 chk("free timebase", 16'h0000, timebase_valid);
    src.pulse(1'b0, 2);
    repeat (10) @(posedge core_clk);
    chk("free sleep", 16'h0001, count_value);
    chk("wake irq", 16'h0001, irq);
    sleep <= 1'b0;
    rd(`STC_ADDR_FLAG);
    wr(`STC_ADDR_CONTROL, 8'h00);
  endtask : t_sleep

  task t_trig;
    set_count(16'h1212);
    @(posedge core_clk);
    special_event_trig <= 2'b01;
    @(posedge core_clk);
    special_event_trig <= 2'b00;
    #1 chk("trig clear", 16'h0000, count_value);
    wr(`STC_ADDR_COUNT_HIGH, 8'h12);
    @(posedge core_clk);
    bus_req <= '{`STC_ADDR_COUNT_LOW, 8'h55, 1'b1, 1'b0};
    special_event_trig <= 2'b10;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    special_event_trig <= 2'b00;
    #1 chk("write wins", 16'h1255, count_value);
  endtask : t_trig

  // Mid-run reset: control falls back, the count bytes must survive
  task t_reset;
    set_count(16'hA55A);
    wr(`STC_ADDR_CONTROL, 8'h08);
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    #1 chk("count kept", 16'hA55A, count_value);
    chk("pins released", 16'h0000, pins_in);
    rd(`STC_ADDR_CONTROL); chk("ctrl cleared", 16'h0000, d);
  endtask : t_reset

  task end_of_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    #3000000;
    fails++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    bus_req = '0;
    sleep = 1'b0;
    special_event_trig = 2'b00;
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_irq();
    t_prescale();
    t_ext();
    t_sleep();
    t_trig();
    t_reset();
    end_of_test();
  end
endmodule : tb_top

/* pkg/stc_consts.svh */
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

// Register offsets on the byte-wide internal bus
`define STC_ADDR_FLAG        8'h0C
`define STC_ADDR_ENABLE      8'h8C
`define STC_ADDR_COUNT_LOW   8'h0E
`define STC_ADDR_COUNT_HIGH  8'h0F
`define STC_ADDR_CONTROL     8'h10

// Control register fields
`define STC_CTRL_RUN_BIT     0
`define STC_CTRL_CS_BIT      1
`define STC_CTRL_SYNC_BIT    2
`define STC_CTRL_OSC_BIT     3
`define STC_CTRL_PS_LSB      4
`define STC_CTRL_PS_MSB      5
`define STC_CTRL_RESET       6'h00

// Flag and enable registers share one layout
`define STC_FLAG_OVF_BIT     0
`define STC_FLAG_RESET       1'h0

// Count limits
`define STC_COUNT_ZERO       16'h0000
`define STC_COUNT_MAX        16'hFFFF

// Instruction clock is the core clock divided by four
`define STC_INSTR_DIV        4
`define STC_PHASE_LAST       2'h3

`endif

/* pkg/stc_pkg.sv */
package stc_pkg;

  typedef struct packed {
    logic [1:0] prescale_select;
    logic       crystal_osc_enable;
    logic       sync_bypass;
    logic       clock_source_select;
    logic       run_control;
  } stc_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } stc_bus_req_t;

  typedef enum logic [2:0] {
    STC_MODE_INTERNAL = 3'b001,
    STC_MODE_EXT_SYNC = 3'b010,
    STC_MODE_EXT_FREE = 3'b100
  } stc_mode_t;

endpackage : stc_pkg

/* verilog/stc_pin_sync.sv */
`timescale 1ns/1ps

module stc_pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;
  logic [WIDTH-1:0] next_rise;

  // Level only moves once the two settled stages agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        next_level[g] = (stage2[g] == stage3[g]) ? stage3[g] : level[g];
        next_rise[g]  = next_level[g] & ~level[g];
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
      rise   <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
      rise   <= next_rise;
    end
  end

endmodule : stc_pin_sync

/* verilog/stc_prescaler.sv */
`timescale 1ns/1ps

module stc_prescaler #(
  parameter int DIV_BITS = 3
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic [1:0] ratio,
  output logic            out_pulse
);

  logic [DIV_BITS-1:0] count;
  logic [DIV_BITS-1:0] next_count;
  logic                next_pulse;

  function automatic logic [DIV_BITS-1:0] last_of(input logic [1:0] r);
    last_of = DIV_BITS'((1 << r) - 1);
  endfunction : last_of

  always_comb begin
    next_count = count;
    next_pulse = 1'b0;
    if (clear) begin
      next_count = '0;
    end else if (tick) begin
      if (count >= last_of(ratio)) begin
        next_count = '0;
        next_pulse = 1'b1;
      end else begin
        next_count = DIV_BITS'(count + 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      count     <= '0;
      out_pulse <= 1'b0;
    end else begin
      count     <= next_count;
      out_pulse <= next_pulse;
    end
  end

endmodule : stc_prescaler

/* verilog/stc_timer.sv */
// Notes on behaviour
// - The count is a high and a low byte that step up from 0000h to FFFFh and wrap to zero.
// - Each wrap sets a sticky overflow flag at bit 0 of the flag register; the interrupt asks only while its enable bit is set.
// - Control bit 1 picks the instruction clock (clear) or rising edges of the external input (set).
// - Control bit 0 runs the counter when set and holds its value when clear.
// - Control bits 5 to 4 divide the input by 1, 2, 4 or 8.
// - Control bit 3 runs the crystal oscillator and forces both oscillator pins to inputs that read zero.
// - With the external source, control bit 2 clear sends the prescaled input through a synchroniser and set bypasses it; with the internal source it does nothing.
// - External edges come from the oscillator input pin when the oscillator is on, else from the dedicated clock pin.
// - The prescaler sits ahead of the synchroniser and counts the selected external input directly.
// - In synchronised external counting the count does not advance in sleep, while the prescaler keeps counting.
// - In unsynchronised external counting the count keeps running in sleep and its overflow can wake the processor.
// - An unsynchronised count is not offered as a capture or compare time base.
// - A special event trigger from either capture/compare unit resets the count.
// - A write to either count byte clears the prescaler.
// - A count write that meets a special event trigger wins over it.
// - Reset clears the control register but never the count bytes.
`timescale 1ns/1ps
`include "stc_consts.svh"

module stc_timer (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire stc_pkg::stc_bus_req_t bus_req,
  output logic               [7:0]  rdata,
  input  wire logic                 sleep,
  input  wire logic          [1:0]  special_event_trig,
  input  wire logic                 ext_count_clock_pin,
  input  wire logic                 osc_input_pin,
  output logic                      irq,
  output logic                      osc_run,
  output logic                      osc_pins_input_only,
  output logic                      timebase_valid,
  output logic               [15:0] count_value
);
  import stc_pkg::*;

  stc_ctrl_t   ctrl;
  stc_ctrl_t   next_ctrl;
  logic [7:0]  count_low_byte;
  logic [7:0]  count_high_byte;
  logic [7:0]  next_low;
  logic [7:0]  next_high;
  logic        overflow_flag;
  logic        next_overflow_flag;
  logic        overflow_irq_enable;
  logic        next_irq_enable;
  logic [7:0]  next_rdata;
  logic        next_irq;
  logic        next_timebase_valid;
  logic [1:0]  phase;
  logic [1:0]  next_phase;
  logic        instr_tick;
  logic [1:0]  pin_rise;
  logic        ext_edge;
  logic        presc_tick;
  logic        presc_clear;
  logic        presc_pulse;
  logic        sync_pulse;
  logic        next_sync_pulse;
  logic        inc;
  logic        wrap;
  logic        wr_low;
  logic        wr_high;
  logic        wr_count;
  logic        trig;
  stc_mode_t   mode;

  function automatic stc_mode_t mode_of(input stc_ctrl_t c);
    if (!c.clock_source_select) begin
      mode_of = STC_MODE_INTERNAL;
    end else if (c.sync_bypass) begin
      mode_of = STC_MODE_EXT_FREE;
    end else begin
      mode_of = STC_MODE_EXT_SYNC;
    end
  endfunction : mode_of

  function automatic logic hit(input logic [7:0] a);
    hit = bus_req.wr && (bus_req.addr == a);
  endfunction : hit

  stc_pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pin_in   ({osc_input_pin, ext_count_clock_pin}),
    .rise     (pin_rise)
  );

  stc_prescaler #(
    .DIV_BITS (3)
  ) u_prescaler (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .tick      (presc_tick),
    .clear     (presc_clear),
    .ratio     (ctrl.prescale_select),
    .out_pulse (presc_pulse)
  );

  // Instruction clock phase, stopped in sleep
  always_comb begin
    next_phase = sleep ? phase : 2'(phase + 2'h1);
    instr_tick = (phase == `STC_PHASE_LAST) && !sleep;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      phase <= 2'h0;
    end else begin
      phase <= next_phase;
    end
  end

  // Source selection and the sync stage after the prescaler
  always_comb begin
    mode     = mode_of(ctrl);
    ext_edge = ctrl.crystal_osc_enable ? pin_rise[1] : pin_rise[0];
    wr_low   = hit(`STC_ADDR_COUNT_LOW);
    wr_high  = hit(`STC_ADDR_COUNT_HIGH);
    wr_count = wr_low | wr_high;
    presc_clear = wr_count;
    trig     = |special_event_trig;
    presc_tick = 1'b0;
    inc        = 1'b0;
    // The sync stage is shut off in sleep, so pulses die here
    next_sync_pulse = presc_pulse && !sleep;
    unique case (mode)
      STC_MODE_INTERNAL: begin
        presc_tick = ctrl.run_control && instr_tick;
        inc        = presc_pulse && !sleep;
      end
      STC_MODE_EXT_SYNC: begin
        presc_tick = ctrl.run_control && ext_edge;
        inc        = sync_pulse && !sleep;
      end
      STC_MODE_EXT_FREE: begin
        presc_tick = ctrl.run_control && ext_edge;
        inc        = presc_pulse;
      end
    endcase
    inc  = inc && ctrl.run_control;
    wrap = inc && !wr_count && !trig &&
           ({count_high_byte, count_low_byte} == `STC_COUNT_MAX);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync_pulse <= 1'b0;
    end else begin
      sync_pulse <= next_sync_pulse;
    end
  end

  // Count bytes
  always_comb begin
    {next_high, next_low} = {count_high_byte, count_low_byte};
    if (wr_count) begin
      // A write stalls counting for that cycle and beats the trigger
      if (wr_low) begin
        next_low = bus_req.wdata;
      end
      if (wr_high) begin
        next_high = bus_req.wdata;
      end
    end else if (trig) begin
      {next_high, next_low} = `STC_COUNT_ZERO;
    end else if (inc) begin
      {next_high, next_low} =
        16'({count_high_byte, count_low_byte} + 16'h0001);
    end
  end

  // Count bytes carry no reset on purpose
  always_ff @(posedge core_clk) begin
    count_low_byte  <= next_low;
    count_high_byte <= next_high;
    count_value     <= {next_high, next_low};
  end

  // Control, flag, enable and read data
  always_comb begin
    next_ctrl           = ctrl;
    next_irq_enable     = overflow_irq_enable;
    next_overflow_flag  = overflow_flag;
    next_rdata          = 8'h00;
    if (hit(`STC_ADDR_CONTROL)) begin
      next_ctrl = bus_req.wdata[`STC_CTRL_PS_MSB:0];
    end
    if (hit(`STC_ADDR_ENABLE)) begin
      next_irq_enable = bus_req.wdata[`STC_FLAG_OVF_BIT];
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `STC_ADDR_FLAG: begin
          next_rdata = {7'h00, overflow_flag};
          next_overflow_flag = 1'b0;
        end
        `STC_ADDR_ENABLE: begin
          next_rdata = {7'h00, overflow_irq_enable};
        end
        `STC_ADDR_COUNT_LOW: begin
          next_rdata = count_low_byte;
        end
        `STC_ADDR_COUNT_HIGH: begin
          next_rdata = count_high_byte;
        end
        `STC_ADDR_CONTROL: begin
          next_rdata = {2'h0, ctrl};
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
    // Set after the read clear so a wrap in the read cycle survives
    if (wrap) begin
      next_overflow_flag = 1'b1;
    end
    // Overflow is level-driven so it can wake a sleeping core
    next_irq = next_overflow_flag && next_irq_enable;
    next_timebase_valid = (mode_of(next_ctrl) != STC_MODE_EXT_FREE);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl                <= `STC_CTRL_RESET;
      overflow_flag       <= `STC_FLAG_RESET;
      overflow_irq_enable <= `STC_FLAG_RESET;
      rdata               <= 8'h00;
      irq                 <= 1'b0;
      osc_run             <= 1'b0;
      osc_pins_input_only <= 1'b0;
      timebase_valid      <= 1'b1;
    end else begin
      ctrl                <= next_ctrl;
      overflow_flag       <= next_overflow_flag;
      overflow_irq_enable <= next_irq_enable;
      rdata               <= next_rdata;
      irq                 <= next_irq;
      osc_run             <= next_ctrl.crystal_osc_enable;
      osc_pins_input_only <= next_ctrl.crystal_osc_enable;
      timebase_valid      <= next_timebase_valid;
    end
  end

endmodule : stc_timer
